// File: rtl/bro_regs.svh
`ifndef BRO_REGS_SVH
`define BRO_REGS_SVH
// overlay control bit position in the I/O data byte
`define BRO_CTRL_EN_BIT   3'd0
// I/O port of the overlay control register
`define BRO_CTRL_PORT     8'h1d
// enable state after reset: boot memory answers
`define BRO_CTRL_RST      1'b1
// lower region ends at 7fffh (a15 clear)
`define BRO_UPPER_BIT     4'd15
// boot window limits per size, in byte addresses
`define BRO_LIM_SMALL     16'h0fff
`define BRO_LIM_MEDIUM    16'h1fff
`define BRO_LIM_LARGE     16'h3fff
`endif

// File: rtl/bro_pkg.sv
package bro_pkg;
    typedef enum logic [1:0] {
        BRO_SZ_SMALL,
        BRO_SZ_MEDIUM,
        BRO_SZ_LARGE
    } bro_size_type;

    typedef struct packed {
        logic        mem_req;
        logic        io_wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bro_req_type;

    typedef struct packed {
        logic        boot_sel;
        logic        ram_sel;
        logic [13:0] boot_addr;
    } bro_sel_type;
endpackage : bro_pkg

// File: rtl/bro_decoder.sv
// Operation
// - after reset boot memory answers reads at 0000h to 0fffh
// - lower region 0000h-7fffh selects boot memory or ram, never both
// - reset sets the boot enable, so boot memory owns its size window at the bottom of the lower region
// - software writes the control bit; cleared sends lower region to ram
// - 8000h-ffffh always selects ram regardless of the enable
// - boot memory up to 128 kbit, occupying 0000h to 3fffh
// - medium strap configures the socket for 64 kbit memory
// - large strap routes high address line to socket instead of medium
`timescale 1ns/10ps
`include "bro_regs.svh"
module bro_decoder (
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    input  wire bro_pkg::bro_req_type req_i,
    input  wire logic               size_strap_medium_i,
    input  wire logic               size_strap_large_i,
    output logic                    boot_en_o,
    output logic                    strap_err_o,
    output bro_pkg::bro_sel_type    sel_o
);
    logic                 boot_en_r;
    logic                 boot_en_nxt;
    bro_pkg::bro_size_type size_r;
    bro_pkg::bro_size_type size_nxt;
    logic                 strap_err_r;
    bro_pkg::bro_sel_type sel_r;
    bro_pkg::bro_sel_type sel_nxt;

    // window top for each fitted size; shared by the decode and the checks
    function automatic logic [15:0] win_limit(
        input bro_pkg::bro_size_type size
    );
        logic [15:0] top;
        top = `BRO_LIM_SMALL;
        unique case (size)
            bro_pkg::BRO_SZ_SMALL:  top = `BRO_LIM_SMALL;
            bro_pkg::BRO_SZ_MEDIUM: top = `BRO_LIM_MEDIUM;
            bro_pkg::BRO_SZ_LARGE:  top = `BRO_LIM_LARGE;
            // the fourth code of the size field is never stored
            default:                top = `BRO_LIM_SMALL;
        endcase
        return top;
    endfunction : win_limit

    // only the largest memory uses socket address line 13
    function automatic logic a13_routed(
        input bro_pkg::bro_size_type size
    );
        return size == bro_pkg::BRO_SZ_LARGE;
    endfunction : a13_routed

    wire ctrl_wr = req_i.io_wr && (req_i.addr[7:0] == `BRO_CTRL_PORT);
    wire upper   = req_i.addr[`BRO_UPPER_BIT];
    wire in_win;
    wire [15:0] lim;

    // straps are static; sampled every cycle, large wins if both fitted
    assign size_nxt = size_strap_large_i  ? bro_pkg::BRO_SZ_LARGE :
                      size_strap_medium_i ? bro_pkg::BRO_SZ_MEDIUM :
                                            bro_pkg::BRO_SZ_SMALL;
    assign lim = win_limit(size_r);
    assign in_win = req_i.addr <= lim;
    assign boot_en_nxt = ctrl_wr ? req_i.wdata[`BRO_CTRL_EN_BIT]
                                 : boot_en_r;

    // lower region above the fitted memory falls to ram so one is always on for a memory request
    always_comb begin
        sel_nxt = '0;
        sel_nxt.boot_addr = req_i.addr[13:0];
        if (req_i.mem_req) begin
            if (!upper && boot_en_r && in_win) begin
                sel_nxt.boot_sel = 1'b1;
            end else begin
                sel_nxt.ram_sel = 1'b1;
            end
        end
        // address line 13 reaches the socket only with the large strap
        if (!a13_routed(size_r)) begin
            sel_nxt.boot_addr[13] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            boot_en_r   <= `BRO_CTRL_RST;
            size_r      <= bro_pkg::BRO_SZ_SMALL;
            strap_err_r <= 1'b0;
            sel_r       <= '0;
        end else begin
            boot_en_r   <= boot_en_nxt;
            size_r      <= size_nxt;
            strap_err_r <= size_strap_large_i && size_strap_medium_i;
            sel_r       <= sel_nxt;
        end
    end

    assign boot_en_o   = boot_en_r;
    assign strap_err_o = strap_err_r;
    assign sel_o       = sel_r;

    excl_sel_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !(sel_o.boot_sel && sel_o.ram_sel))
        else $error("boot and ram selected together");

    upper_ram_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && req_i.addr[15] |=> sel_o.ram_sel && !sel_o.boot_sel)
        else $error("upper request missed ram");

    reset_boot_a: assert property (
        @(posedge ref_clk_i)
        srst_i |=> boot_en_o)
        else $error("boot enable not set by reset");

    ctrl_write_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        ctrl_wr |=> boot_en_o == $past(req_i.wdata[`BRO_CTRL_EN_BIT]))
        else $error("control write not taken");

    disabled_ram_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && !boot_en_o && !ctrl_wr |=> sel_o.ram_sel)
        else $error("disabled boot still answered");

    small_win_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && boot_en_o && req_i.addr <= 16'h0fff
        |=> sel_o.boot_sel)
        else $error("boot missed in small window");

    large_win_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && boot_en_o && size_r == bro_pkg::BRO_SZ_LARGE
        && req_i.addr >= 16'h2000 && req_i.addr <= 16'h3fff
        |=> sel_o.boot_sel && sel_o.boot_addr[13])
        else $error("large boot window wrong");

    medium_a13_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        size_r == bro_pkg::BRO_SZ_MEDIUM |=> !sel_o.boot_addr[13])
        else $error("a13 driven for medium size");

    idle_quiet_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !req_i.mem_req |=> !sel_o.boot_sel && !sel_o.ram_sel)
        else $error("select raised without request");

    one_sel_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req |=> sel_o.boot_sel || sel_o.ram_sel)
        else $error("request left unanswered");

    reset_sel_a: assert property (
        @(posedge ref_clk_i)
        srst_i |=> sel_o == '0 && !strap_err_o)
        else $error("outputs not cleared by reset");

    hold_en_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !ctrl_wr |=> $stable(boot_en_o))
        else $error("boot enable moved without write");

    en_clear_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        ctrl_wr && !req_i.wdata[`BRO_CTRL_EN_BIT] |=> !boot_en_o)
        else $error("control write did not disable");

    boot_gate_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        sel_o.boot_sel |-> $past(boot_en_o))
        else $error("boot selected while disabled");

    beyond_win_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && !req_i.addr[15] && req_i.addr > win_limit(size_r)
        |=> sel_o.ram_sel)
        else $error("address above window missed ram");

    small_top_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && size_r == bro_pkg::BRO_SZ_SMALL
        && !req_i.addr[15] && req_i.addr[14:12] != 3'h0
        |=> sel_o.ram_sel)
        else $error("small boot answered above window");

    medium_win_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && boot_en_o && size_r == bro_pkg::BRO_SZ_MEDIUM
        && req_i.addr >= 16'h1000 && req_i.addr <= 16'h1fff
        |=> sel_o.boot_sel && !sel_o.boot_addr[13])
        else $error("medium boot window wrong");

    addr_low_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req |=> sel_o.boot_addr[12:0] == $past(req_i.addr[12:0]))
        else $error("boot address bits lost");

    large_a13_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        req_i.mem_req && a13_routed(size_r)
        |=> sel_o.boot_addr[13] == $past(req_i.addr[13]))
        else $error("a13 not routed for large size");

    strap_err_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        size_strap_large_i && size_strap_medium_i |=> strap_err_o)
        else $error("double strap not flagged");

    strap_ok_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !(size_strap_large_i && size_strap_medium_i) |=> !strap_err_o)
        else $error("strap error without double strap");

    size_large_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        size_strap_large_i |=> size_r == bro_pkg::BRO_SZ_LARGE)
        else $error("large strap not taken");

    size_medium_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        size_strap_medium_i && !size_strap_large_i
        |=> size_r == bro_pkg::BRO_SZ_MEDIUM)
        else $error("medium strap not taken");

    // small size is the default when no strap is fitted
    size_small_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !size_strap_medium_i && !size_strap_large_i
        |=> size_r == bro_pkg::BRO_SZ_SMALL)
        else $error("small size not taken");
endmodule : bro_decoder

// File: tb/bro_host.sv
`timescale 1ns/10ps
module bro_host (
    input  wire logic [31:0]     rnd_i,
    output bro_pkg::bro_req_type req_o
);
    // memory and i/o cycles never overlap, as on the real bus
    wire io = !rnd_i[0] && rnd_i[3:1] == 3'h0;
    assign req_o.mem_req = rnd_i[0];
    assign req_o.io_wr = io;
    // short addresses favoured so each window edge sees traffic
    assign req_o.addr = io && rnd_i[4] ? 16'h001d
                                       : rnd_i[20:5] >> rnd_i[23:21];
    assign req_o.wdata = rnd_i[31:24];
endmodule : bro_host

// File: tb/tb.sv
`timescale 1ns/10ps
`include "bro_regs.svh"
`define CHK(n,e,s) begin total_checks++; if ((s) !== (e)) begin \
    failures++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
    logic                 ref_clk_i = 0, srst_i = 1, med = 0, lrg = 0;
    logic                 en = 1, pm = 0, pl = 0, bs;
    logic [31:0]          rnd = '0;
    logic [15:0]          lim;
    logic [13:0]          exp_ba;
    logic                 boot_en_o, strap_err_o;
    bro_pkg::bro_req_type req;
    bro_pkg::bro_sel_type sel_o;
    int                   failures = 0, total_checks = 0, cyc = 0;
    bro_host bro_host_inst (.rnd_i(rnd), .req_o(req));
    bro_decoder bro_decoder_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .req_i(req), .size_strap_medium_i(med), .size_strap_large_i(lrg),
        .boot_en_o(boot_en_o), .strap_err_o(strap_err_o), .sel_o(sel_o));
    task automatic complete_run;
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // model state is taken before the edge, results looked at after it
    always @(posedge ref_clk_i) begin
        lim = pl ? `BRO_LIM_LARGE : pm ? `BRO_LIM_MEDIUM : `BRO_LIM_SMALL;
        bs = !srst_i && req.mem_req && en && req.addr <= lim;
        if (srst_i || req.io_wr && req.addr[7:0] == 8'h1d) begin
            en = srst_i | req.wdata[0];
        end
        {pm, pl} = srst_i ? 2'h0 : {med, lrg};
        #1;
        `CHK("boot_sel", bs, sel_o.boot_sel)
        `CHK("ram_sel", !srst_i && req.mem_req && !bs, sel_o.ram_sel)
        `CHK("boot_en", en, boot_en_o)
        `CHK("strap_err", !srst_i && med && lrg, strap_err_o)
        if (bs) begin
            exp_ba = {lim[13] & req.addr[13], req.addr[12:0]};
            `CHK("boot_addr", exp_ba, sel_o.boot_addr)
        end
        if (++cyc > 4000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(55535));
        repeat (2) @(negedge ref_clk_i);
        srst_i = 0;
        // a second reset mid-run must restore the boot overlay
        for (int i = 0; i < 3000; i++) begin
            @(negedge ref_clk_i);
            srst_i = (i == 1500);
            if (i % 97 == 0) {med, lrg} = 2'($urandom);
            rnd = $urandom;
        end
        complete_run();
    end
endmodule : tb
